// ==== include/i2c_client_pkg.sv ====
package i2c_client_pkg;

  // four client modes; the _SS ones flag every start, restart and stop
  typedef enum logic [1:0] {
    PM_7BIT,
    PM_10BIT,
    PM_7BIT_SS,
    PM_10BIT_SS
  } port_mode_t;

  // software controls, static while a transfer runs
  typedef struct packed {
    port_mode_t mode;
    logic       start_irq_enable;
    logic       stop_irq_enable;
    logic       address_hold_enable;
    logic       data_hold_enable;
    logic       buffer_overwrite_enable;
    logic       clock_stretch_enable;
    logic       ack_value_to_send;
  } port_ctrl_t;

  // flags seen by software
  typedef struct packed {
    logic port_irq_flag;
    logic buffer_full_flag;
    logic receive_overflow;
    logic ack_received_status;
    logic ack_time_flag;
    logic address_update_needed;
    logic begin_seen;
    logic end_seen;
    logic read_write;
  } port_status_t;

  // levels carried into the link domain
  typedef struct packed {
    logic addr_hold;
    logic data_hold;
    logic overwrite;
    logic stretch;
    logic ack_level;
    logic mode10;
    logic full;
    logic ov;
  } link_ctrl_t;

  // byte report from the link domain, stable while its event crosses
  typedef struct packed {
    logic [7:0] data;
    logic       match;
    logic       is_addr;
    logic       rw;
    logic       nack;
    logic       ack_seen;
    logic       sw_ack;
  } byte_info_t;

  localparam int         NUM_EV       = 6;
  localparam int         EV_START     = 0;
  localparam int         EV_STOP      = 1;
  localparam int         EV_BYTE      = 2;
  localparam int         EV_ACKT      = 3;
  localparam int         EV_ACKEND    = 4;
  localparam int         EV_UPD       = 5;
  localparam logic [4:0] TEN_HI_PAT   = 5'h1e;
  localparam logic [7:0] OWN_ADDR_RST = 8'h00;
  localparam logic [3:0] BITS_DATA    = 4'h8;
  localparam logic [3:0] BITS_ACK     = 4'h9;

endpackage

// ==== logic/i2c_client_addr_receive.sv ====
module i2c_client_addr_receive (
  input  wire logic                         i_sys_clk,
  input  wire logic                         i_rst_b,
  input  wire logic                         i_link_clk,
  input  wire i2c_client_pkg::port_ctrl_t   i_ctrl,
  input  wire logic                         i_own_addr_wr,
  input  wire logic [7:0]                   i_own_addr_data,
  input  wire logic                         i_clock_release,
  input  wire logic                         i_irq_clr,
  input  wire logic                         i_buf_rd,
  input  wire logic                         i_ovf_clr,
  output logic                              o_clock_release_ack,
  output i2c_client_pkg::port_status_t      o_status,
  output logic [7:0]                        o_data_buffer,
  input  wire logic                         i_scl,
  input  wire logic                         i_sda,
  output logic                              o_scl_out,
  output logic                              o_scl_oe_b,
  output logic                              o_sda_out,
  output logic                              o_sda_oe_b
);

  typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_ADDR_LO, ST_DATA, ST_WAIT} link_state_t;

  // ---------------- system domain ----------------
  i2c_client_pkg::port_status_t st_ff;
  logic [7:0]                   buf_ff;
  logic [7:0]                   own_addr_ff;
  logic                         rel_tgl_ff;
  logic                         aw_tgl_ff;
  logic [i2c_client_pkg::NUM_EV-1:0] ev_s1_ff, ev_s2_ff, ev_s3_ff, ev_pulse;
  i2c_client_pkg::link_ctrl_t   sys_lc;
  logic                         ss_mode;

  // ---------------- link domain ----------------
  i2c_client_pkg::link_ctrl_t   lc_s1_ff, lc_s2_ff;
  i2c_client_pkg::byte_info_t   info_ff;
  logic                         lrst_s1_ff, lrst_s2_ff, link_rst_b;
  logic [1:0]                   sw_s1_ff, sw_s2_ff, sw_s3_ff;
  logic                         rel_ev, aw_ev;
  logic                         scl_s1_ff, scl_s2_ff, scl_d_ff;
  logic                         sda_s1_ff, sda_s2_ff, sda_d_ff;
  logic                         scl_rise, scl_fall, start_det, stop_det, low_seen_ff;
  logic [3:0]                   bit_cnt_ff;
  logic [7:0]                   shift_ff;
  logic [7:0]                   own_ff;
  link_state_t                  state_ff, after_ff;
  logic                         scl_oe_b_ff, sda_oe_b_ff;
  logic                         in_ack_ff, ack_pend_ff, upd_hold_ff, prior_ff;
  logic                         post_hold_ff, post_upd_ff;
  logic [i2c_client_pkg::NUM_EV-1:0] ev_tgl_ff, ev_fire;
  logic                         byte_done, ack_end, nack, hi10;
  logic                         d_match, d_addr, d_ev, d_sw, d_upd, d_hold, d_prior;
  link_state_t                  d_after;

  assign ss_mode = (i_ctrl.mode == i2c_client_pkg::PM_7BIT_SS) ||
                   (i_ctrl.mode == i2c_client_pkg::PM_10BIT_SS);
  assign sys_lc = '{addr_hold: i_ctrl.address_hold_enable,
                    data_hold: i_ctrl.data_hold_enable,
                    overwrite: i_ctrl.buffer_overwrite_enable,
                    stretch:   i_ctrl.clock_stretch_enable,
                    ack_level: i_ctrl.ack_value_to_send,
                    mode10:    (i_ctrl.mode == i2c_client_pkg::PM_10BIT) ||
                               (i_ctrl.mode == i2c_client_pkg::PM_10BIT_SS),
                    full:      st_ff.buffer_full_flag,
                    ov:        st_ff.receive_overflow};

  // link events: toggle in link domain, three flops here, pulse on change
  genvar gi;
  generate
    for (gi = 0; gi < i2c_client_pkg::NUM_EV; gi++) begin : g_ev_sync
      always_ff @(posedge i_sys_clk) begin
        if (!i_rst_b) begin
          ev_s1_ff[gi] <= 1'b0;
          ev_s2_ff[gi] <= 1'b0;
          ev_s3_ff[gi] <= 1'b0;
        end else begin
          ev_s1_ff[gi] <= ev_tgl_ff[gi];
          ev_s2_ff[gi] <= ev_s1_ff[gi];
          ev_s3_ff[gi] <= ev_s2_ff[gi];
        end
      end
      assign ev_pulse[gi] = ev_s2_ff[gi] ^ ev_s3_ff[gi];
    end
  endgenerate

  // software strobes to the link domain as toggles
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      rel_tgl_ff  <= 1'b0;
      aw_tgl_ff   <= 1'b0;
      own_addr_ff <= i2c_client_pkg::OWN_ADDR_RST;
    end else begin
      if (i_clock_release) begin
        rel_tgl_ff <= ~rel_tgl_ff;
      end
      if (i_own_addr_wr) begin
        aw_tgl_ff   <= ~aw_tgl_ff;
        own_addr_ff <= i_own_addr_data;
      end
    end
  end

  // status flags: in every set/clear pair the set wins, except end_seen, which a start clears even when a stop comes in the same cycle
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      st_ff  <= '0;
      buf_ff <= 8'h00;
    end else begin
      if ((ev_pulse[i2c_client_pkg::EV_START] && (ss_mode || i_ctrl.start_irq_enable)) ||
          (ev_pulse[i2c_client_pkg::EV_STOP] && (ss_mode || i_ctrl.stop_irq_enable)) ||
          ev_pulse[i2c_client_pkg::EV_BYTE] ||
          (ev_pulse[i2c_client_pkg::EV_ACKEND] && info_ff.sw_ack && !info_ff.ack_seen)) begin
        st_ff.port_irq_flag <= 1'b1;
      end else if (i_irq_clr) begin
        st_ff.port_irq_flag <= 1'b0;
      end
      if (ev_pulse[i2c_client_pkg::EV_BYTE] && info_ff.match && !info_ff.nack) begin
        buf_ff                 <= info_ff.data;
        st_ff.buffer_full_flag <= 1'b1;
      end else if (i_buf_rd) begin
        st_ff.buffer_full_flag <= 1'b0;
      end
      if (ev_pulse[i2c_client_pkg::EV_BYTE] && info_ff.match && st_ff.buffer_full_flag) begin
        st_ff.receive_overflow <= 1'b1;
      end else if (i_ovf_clr) begin
        st_ff.receive_overflow <= 1'b0;
      end
      if (ev_pulse[i2c_client_pkg::EV_BYTE] && info_ff.match && info_ff.is_addr) begin
        st_ff.read_write <= info_ff.rw;
      end
      if (ev_pulse[i2c_client_pkg::EV_ACKEND]) begin
        st_ff.ack_received_status <= info_ff.ack_seen;
        st_ff.ack_time_flag       <= 1'b0;
      end
      if (ev_pulse[i2c_client_pkg::EV_ACKT]) begin
        st_ff.ack_time_flag <= 1'b1;
      end
      if (ev_pulse[i2c_client_pkg::EV_UPD]) begin
        st_ff.address_update_needed <= 1'b1;
      end else if (i_own_addr_wr) begin
        st_ff.address_update_needed <= 1'b0;
      end
      if (ev_pulse[i2c_client_pkg::EV_START]) begin
        st_ff.begin_seen <= 1'b1;
        st_ff.end_seen   <= 1'b0;
      end else if (ev_pulse[i2c_client_pkg::EV_STOP]) begin
        st_ff.end_seen   <= 1'b1;
        st_ff.begin_seen <= 1'b0;
      end
    end
  end

  assign o_status            = st_ff;
  assign o_data_buffer       = buf_ff;
  assign o_clock_release_ack = rel_tgl_ff;

  // ---------------- link domain ----------------
  // reset is carried over through two flops so link flops leave reset on a link-clock edge
  always_ff @(posedge i_link_clk) begin
    lrst_s1_ff <= i_rst_b;
    lrst_s2_ff <= lrst_s1_ff;
  end
  assign link_rst_b = lrst_s2_ff;

  always_ff @(posedge i_link_clk) begin
    if (!link_rst_b) begin
      scl_s1_ff <= 1'b1;
      scl_s2_ff <= 1'b1;
      scl_d_ff  <= 1'b1;
      sda_s1_ff <= 1'b1;
      sda_s2_ff <= 1'b1;
      sda_d_ff  <= 1'b1;
      lc_s1_ff  <= '0;
      lc_s2_ff  <= '0;
      sw_s1_ff  <= 2'h0;
      sw_s2_ff  <= 2'h0;
      sw_s3_ff  <= 2'h0;
    end else begin
      scl_s1_ff <= i_scl;
      scl_s2_ff <= scl_s1_ff;
      scl_d_ff  <= scl_s2_ff;
      sda_s1_ff <= i_sda;
      sda_s2_ff <= sda_s1_ff;
      sda_d_ff  <= sda_s2_ff;
      lc_s1_ff  <= sys_lc;
      lc_s2_ff  <= lc_s1_ff;
      sw_s1_ff  <= {aw_tgl_ff, rel_tgl_ff};
      sw_s2_ff  <= sw_s1_ff;
      sw_s3_ff  <= sw_s2_ff;
    end
  end

  assign rel_ev    = sw_s2_ff[0] ^ sw_s3_ff[0];
  assign aw_ev     = sw_s2_ff[1] ^ sw_s3_ff[1];
  assign scl_rise  = scl_s2_ff & ~scl_d_ff;
  assign scl_fall  = ~scl_s2_ff & scl_d_ff;
  assign start_det = scl_s2_ff & scl_d_ff & sda_d_ff & ~sda_s2_ff;
  // a stop needs a low clock phase since the start, else only the start counts
  assign stop_det  = scl_s2_ff & scl_d_ff & ~sda_d_ff & sda_s2_ff & low_seen_ff;

  always_ff @(posedge i_link_clk) begin
    if (!link_rst_b) begin
      low_seen_ff <= 1'b0;
      bit_cnt_ff  <= 4'h0;
      shift_ff    <= 8'h00;
    end else if (start_det || stop_det) begin
      low_seen_ff <= 1'b0;
      bit_cnt_ff  <= 4'h0;
    end else begin
      if (!scl_s2_ff) begin
        low_seen_ff <= 1'b1;
      end
      if (scl_rise && bit_cnt_ff < i2c_client_pkg::BITS_DATA) begin
        shift_ff   <= {shift_ff[6:0], sda_s2_ff};
        bit_cnt_ff <= bit_cnt_ff + 4'h1;
      end else if (scl_rise && bit_cnt_ff == i2c_client_pkg::BITS_DATA) begin
        bit_cnt_ff <= i2c_client_pkg::BITS_ACK;
      end else if (scl_fall && bit_cnt_ff == i2c_client_pkg::BITS_ACK) begin
        bit_cnt_ff <= 4'h0;
      end
    end
  end

  always_ff @(posedge i_link_clk) begin
    if (!link_rst_b) begin
      own_ff <= i2c_client_pkg::OWN_ADDR_RST;
    end else if (aw_ev) begin
      own_ff <= own_addr_ff; // held stable in the system domain until the toggle lands
    end
  end

  assign byte_done = scl_fall && (bit_cnt_ff == i2c_client_pkg::BITS_DATA) && !in_ack_ff &&
                     (state_ff == ST_ADDR || state_ff == ST_ADDR_LO || state_ff == ST_DATA);
  assign ack_end   = scl_fall && (bit_cnt_ff == i2c_client_pkg::BITS_ACK) && in_ack_ff;
  assign nack      = lc_s2_ff.overwrite ? lc_s2_ff.ov : (lc_s2_ff.full | lc_s2_ff.ov);
  assign hi10      = (shift_ff[7:3] == i2c_client_pkg::TEN_HI_PAT) &&
                     (shift_ff[2:1] == own_ff[2:1]) && !shift_ff[0];

  // what to do with the byte just completed
  always_comb begin
    d_match = 1'b0;
    d_addr  = 1'b0;
    d_ev    = 1'b0;
    d_sw    = 1'b0;
    d_upd   = 1'b0;
    d_hold  = 1'b0;
    d_prior = prior_ff;
    d_after = ST_WAIT;
    case (state_ff)
      ST_ADDR: begin
        d_addr = 1'b1;
        if (!lc_s2_ff.mode10) begin
          d_match = (shift_ff[7:1] == own_ff[7:1]);
          d_hold  = shift_ff[0] | lc_s2_ff.stretch;
          d_after = shift_ff[0] ? ST_WAIT : ST_DATA;
        end else if (hi10) begin
          d_match = 1'b1;
          d_upd   = 1'b1;
          d_prior = 1'b0;
          d_after = ST_ADDR_LO;
        end else if ((shift_ff[7:3] == i2c_client_pkg::TEN_HI_PAT) &&
                     (shift_ff[2:1] == own_ff[2:1]) && prior_ff) begin
          d_match = 1'b1;
          d_hold  = 1'b1;
        end else begin
          d_prior = 1'b0;
        end
        d_ev = d_match;
        d_sw = d_match & lc_s2_ff.addr_hold;
      end
      ST_ADDR_LO: begin
        d_addr  = 1'b1;
        d_ev    = 1'b1;
        d_upd   = 1'b1;
        d_match = (shift_ff == own_ff);
        d_prior = d_match;
        d_after = d_match ? ST_DATA : ST_WAIT;
        d_sw    = d_match & lc_s2_ff.addr_hold;
      end
      ST_DATA: begin
        d_match = 1'b1;
        d_ev    = 1'b1;
        d_hold  = lc_s2_ff.stretch;
        d_after = ST_DATA;
        d_sw    = lc_s2_ff.data_hold;
      end
      default: begin
        d_ev = 1'b0;
      end
    endcase
  end

  always_comb begin
    ev_fire = '0;
    ev_fire[i2c_client_pkg::EV_START]  = start_det;
    ev_fire[i2c_client_pkg::EV_STOP]   = stop_det & ~start_det;
    ev_fire[i2c_client_pkg::EV_BYTE]   = byte_done & d_ev & ~start_det & ~stop_det;
    ev_fire[i2c_client_pkg::EV_ACKT]   = byte_done & d_ev & d_sw & ~start_det & ~stop_det;
    ev_fire[i2c_client_pkg::EV_ACKEND] = ack_end & ~start_det & ~stop_det;
    ev_fire[i2c_client_pkg::EV_UPD]    = ack_end & post_upd_ff & ~start_det & ~stop_det;
  end

  always_ff @(posedge i_link_clk) begin
    if (!link_rst_b) begin
      ev_tgl_ff <= '0;
    end else begin
      ev_tgl_ff <= ev_tgl_ff ^ ev_fire;
    end
  end

  // pin drive, state and acknowledge handling
  always_ff @(posedge i_link_clk) begin
    if (!link_rst_b) begin
      state_ff     <= ST_IDLE;
      after_ff     <= ST_IDLE;
      scl_oe_b_ff  <= 1'b1;
      sda_oe_b_ff  <= 1'b1;
      in_ack_ff    <= 1'b0;
      ack_pend_ff  <= 1'b0;
      upd_hold_ff  <= 1'b0;
      prior_ff     <= 1'b0;
      post_hold_ff <= 1'b0;
      post_upd_ff  <= 1'b0;
      info_ff      <= '0;
    end else if (start_det || stop_det) begin
      state_ff    <= start_det ? ST_ADDR : ST_IDLE;
      scl_oe_b_ff <= 1'b1;
      sda_oe_b_ff <= 1'b1;
      in_ack_ff   <= 1'b0;
      ack_pend_ff <= 1'b0;
      upd_hold_ff <= 1'b0;
      if (stop_det && !start_det) begin
        prior_ff <= 1'b0;
      end
    end else begin
      if (byte_done) begin
        prior_ff <= d_prior;
        if (!d_ev) begin
          state_ff <= ST_WAIT;
        end else begin
          in_ack_ff    <= 1'b1;
          after_ff     <= d_after;
          post_hold_ff <= d_hold;
          post_upd_ff  <= d_upd;
          info_ff      <= '{data: shift_ff, match: d_match, is_addr: d_addr, rw: shift_ff[0],
                            nack: nack, ack_seen: 1'b1, sw_ack: d_sw};
          if (d_sw) begin
            scl_oe_b_ff <= 1'b0;
            ack_pend_ff <= 1'b1;
          end else begin
            sda_oe_b_ff <= ~(d_match & ~nack);
          end
        end
      end
      if (scl_rise && bit_cnt_ff == i2c_client_pkg::BITS_DATA && in_ack_ff) begin
        info_ff.ack_seen <= sda_s2_ff;
      end
      if (ack_end) begin
        in_ack_ff   <= 1'b0;
        sda_oe_b_ff <= 1'b1;
        state_ff    <= after_ff;
        if (post_upd_ff) begin
          scl_oe_b_ff <= 1'b0;
          upd_hold_ff <= 1'b1;
        end else if (post_hold_ff) begin
          scl_oe_b_ff <= 1'b0;
        end
      end
      if (rel_ev && ack_pend_ff) begin
        sda_oe_b_ff <= lc_s2_ff.ack_level;
        ack_pend_ff <= 1'b0;
        scl_oe_b_ff <= 1'b1;
      end else if (rel_ev && !upd_hold_ff && !in_ack_ff) begin
        scl_oe_b_ff <= 1'b1;
      end
      if (aw_ev && upd_hold_ff) begin
        upd_hold_ff <= 1'b0;
        scl_oe_b_ff <= 1'b1;
      end
    end
  end

  assign o_scl_out  = 1'b0;
  assign o_sda_out  = 1'b0;
  assign o_scl_oe_b = scl_oe_b_ff;
  assign o_sda_oe_b = sda_oe_b_ff;

  // ---------------- checks ----------------
  a_ack_slot_only: assert property (@(posedge i_link_clk) disable iff (!link_rst_b)
    !sda_oe_b_ff |-> (bit_cnt_ff == i2c_client_pkg::BITS_DATA ||
                      bit_cnt_ff == i2c_client_pkg::BITS_ACK)) else $error("data driven outside ack");

  a_auto_ack_drive: assert property (@(posedge i_link_clk) disable iff (!link_rst_b)
    (byte_done && d_ev && !d_sw && d_match && !nack && !start_det && !stop_det)
    |=> !sda_oe_b_ff && scl_oe_b_ff) else $error("automatic ack missing");

  a_sw_ack_value: assert property (@(posedge i_link_clk) disable iff (!link_rst_b)
    (rel_ev && ack_pend_ff && !start_det && !stop_det && !ack_end)
    |=> (sda_oe_b_ff == $past(lc_s2_ff.ack_level)) && scl_oe_b_ff) else $error("software ack wrong");

  a_nomatch_quiet: assert property (@(posedge i_link_clk) disable iff (!link_rst_b)
    (byte_done && !d_ev && !start_det && !stop_det)
    |=> state_ff == ST_WAIT && $stable(ev_tgl_ff)) else $error("mismatch not silent");

  a_acktime_gate: assert property (@(posedge i_link_clk) disable iff (!link_rst_b)
    ev_fire[i2c_client_pkg::EV_ACKT] |-> (lc_s2_ff.addr_hold || lc_s2_ff.data_hold))
    else $error("ack time without hold");

  sequence s_upd_ack_end;
    ack_end && post_upd_ff && !start_det && !stop_det;
  endsequence
  a_upd_clock_hold: assert property (@(posedge i_link_clk) disable iff (!link_rst_b)
    s_upd_ack_end |=> !scl_oe_b_ff && upd_hold_ff ##1 (!scl_oe_b_ff)[*2])
    else $error("clock not held for address update");

  a_upd_release: assert property (@(posedge i_link_clk) disable iff (!link_rst_b)
    (aw_ev && upd_hold_ff && !start_det && !stop_det) |=> scl_oe_b_ff && !upd_hold_ff)
    else $error("address write did not release");

  a_restart_reset: assert property (@(posedge i_link_clk) disable iff (!link_rst_b)
    start_det |=> state_ff == ST_ADDR && bit_cnt_ff == 4'h0 && scl_oe_b_ff && sda_oe_b_ff)
    else $error("restart did not reset");

  a_stop_idle: assert property (@(posedge i_link_clk) disable iff (!link_rst_b)
    (stop_det && !start_det) |=> state_ff == ST_IDLE) else $error("stop did not idle");

  a_irq_on_byte: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
    ev_pulse[i2c_client_pkg::EV_BYTE] |=> st_ff.port_irq_flag) else $error("byte irq missing");

  a_start_flag: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
    ev_pulse[i2c_client_pkg::EV_START] |=> st_ff.begin_seen && !st_ff.end_seen)
    else $error("start not flagged");

endmodule

// ==== verif/i2c_client_addr_receive_tb_top.sv ====
module i2c_client_addr_receive_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic                         sys_clk   = 1'b0;
  logic                         link_clk  = 1'b0;
  logic                         rst_b     = 1'b0;
  i2c_client_pkg::port_ctrl_t   ctrl      = '0;
  logic [4:0]                   strb      = '0;
  logic [7:0]                   own_data  = '0;
  logic [7:0]                   buf_q;
  i2c_client_pkg::port_status_t st;
  logic                         scl, sda, scl_oe_b, sda_oe_b, ack;
  logic                         scl_o, sda_o, rel_ack;
  int                           error_cnt = 0;
  int                           compares  = 0;
  initial forever #50 sys_clk = ~sys_clk;
  // offset so link edges never line up with system edges
  initial begin
    #7;
    forever #24 link_clk = ~link_clk;
  end
  // strobes: 0 release, 1 irq clear, 2 buffer read, 3 overflow clear, 4 own address write
  i2c_client_addr_receive dut_u (
    .i_sys_clk(sys_clk), .i_rst_b(rst_b), .i_link_clk(link_clk), .i_ctrl(ctrl),
    .i_own_addr_wr(strb[4]), .i_own_addr_data(own_data), .i_clock_release(strb[0]),
    .i_irq_clr(strb[1]), .i_buf_rd(strb[2]), .i_ovf_clr(strb[3]),
    .o_clock_release_ack(rel_ack), .o_status(st), .o_data_buffer(buf_q), .i_scl(scl), .i_sda(sda),
    .o_scl_out(scl_o), .o_scl_oe_b(scl_oe_b), .o_sda_out(sda_o), .o_sda_oe_b(sda_oe_b));
  i2c_host_model host_u (.i_scl_oe_b(scl_oe_b), .i_sda_oe_b(sda_oe_b), .o_scl(scl), .o_sda(sda));
  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    if (error_cnt == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic gap(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  task automatic pulse(input logic [4:0] m);
    @(posedge sys_clk);
    strb <= m;
    @(posedge sys_clk);
    strb <= '0;
  endtask
  // also clears the irq flag and the buffer full flag, so each step starts clean
  task automatic cfg(input i2c_client_pkg::port_ctrl_t c, input logic [7:0] a);
    @(posedge sys_clk);
    ctrl     <= c;
    own_data <= a;
    strb     <= 5'h16;
    @(posedge sys_clk);
    strb <= '0;
  endtask
  task automatic rel_later();
    gap(30);
    pulse(5'h01);
  endtask
  // status bit 4 is ack time, bit 3 address update needed
  task automatic wait_bit(input int idx);
    int n;
    for (n = 0; n < 3000 && st[idx] !== 1'b1; n++) @(negedge sys_clk);
    if (n == 3000) begin
      error_cnt++;
      summarize();
    end
  endtask
  task automatic s_auto();
    i2c_client_pkg::port_ctrl_t c;
    c = '0;
    c.mode = i2c_client_pkg::PM_7BIT_SS;
    c.clock_stretch_enable = 1'b1;
    cfg(c, 8'ha5);
    host_u.start();
    gap(20);
    chk({st.begin_seen, st.port_irq_flag}, 2'b11);
    pulse(5'h06);
    host_u.xbyte(8'ha4, ack);
    gap(10);
    chk({ack, buf_q, st.buffer_full_flag, st.read_write}, 11'h692);
    chk({st.port_irq_flag, st.ack_time_flag, st.ack_received_status, scl}, 4'h8);
    fork
      host_u.xbyte(8'h3c, ack);
      rel_later();
    join
    gap(10);
    chk({ack, st.receive_overflow, buf_q}, 10'h0a4 | 10'h100);
    chk(rel_ack, 1'b1);
    pulse(5'h06);
    fork
      host_u.stop();
      rel_later();
    join
    gap(20);
    chk({st.end_seen, st.port_irq_flag}, 2'b11);
    pulse(5'h0e);
    gap(2);
    chk({st.port_irq_flag, st.buffer_full_flag, st.receive_overflow}, 3'b000);
  endtask
  task automatic s_nomatch();
    i2c_client_pkg::port_ctrl_t c;
    c = '0;
    c.mode = i2c_client_pkg::PM_7BIT;
    c.stop_irq_enable = 1'b1;
    cfg(c, 8'ha4);
    host_u.start();
    host_u.xbyte(8'h10, ack);
    gap(10);
    chk({ack, st.port_irq_flag, st.buffer_full_flag, buf_q}, 11'h0a4);
    host_u.stop();
    gap(20);
    chk(st.port_irq_flag, 1'b1);
  endtask
  task automatic s_hold();
    i2c_client_pkg::port_ctrl_t c;
    for (int v = 1; v >= 0; v--) begin
      c = '0;
      c.mode = i2c_client_pkg::PM_7BIT;
      c.address_hold_enable = 1'b1;
      c.ack_value_to_send = v[0];
      cfg(c, 8'ha4);
      host_u.start();
      fork
        host_u.xbyte(8'ha4, ack);
        begin
          wait_bit(4);
          chk(st.port_irq_flag, 1'b1);
          pulse(5'h01);
        end
      join
      gap(10);
      chk({ack, st.ack_received_status}, {!v[0], v[0]});
      host_u.stop();
    end
  endtask
  task automatic s_ten();
    i2c_client_pkg::port_ctrl_t c;
    c = '0;
    c.mode = i2c_client_pkg::PM_10BIT;
    cfg(c, 8'hf4);
    host_u.start();
    host_u.xbyte(8'hf4, ack);
    wait_bit(3);
    chk(ack, 1'b1);
    fork
      host_u.xbyte(8'h5b, ack);
      begin
        gap(15);
        chk(scl, 1'b0);
        cfg(c, 8'h5a);
        gap(2);
        chk(st.address_update_needed, 1'b0);
      end
    join
    wait_bit(3);
    chk(st.port_irq_flag, 1'b1);
    chk(ack, 1'b0);
    fork
      host_u.stop();
      begin
        gap(15);
        chk(scl, 1'b0);
        cfg(c, 8'hf4);
      end
    join
  endtask
  initial begin
    gap(12);
    chk({st, buf_q, scl_oe_b, sda_oe_b, scl_o, sda_o}, 21'hc);
    @(posedge sys_clk);
    rst_b <= 1'b1;
    gap(8);
    s_auto();
    s_nomatch();
    s_hold();
    s_ten();
    chk(24'(host_u.tmo), 24'h0);
    summarize();
  end
endmodule

// ==== verif/i2c_host_model.sv ====
module i2c_host_model (
  input  wire logic i_scl_oe_b,
  input  wire logic i_sda_oe_b,
  output logic      o_scl,
  output logic      o_sda
);
  timeunit 1ns;
  timeprecision 1ns;
  logic scl_d = 1'b1;
  logic sda_d = 1'b1;
  int   tmo   = 0;
  // pull-ups: a line is low while either side pulls it
  assign o_scl = scl_d & i_scl_oe_b;
  assign o_sda = sda_d & i_sda_oe_b;
  // a stretched clock is waited out, but never forever
  task automatic hi();
    #400;
    scl_d = 1'b1;
    for (int n = 0; n < 500 && !o_scl; n++) #100;
    if (!o_scl) tmo++;
    #400;
  endtask
  task automatic start();
    sda_d = 1'b1;
    hi();
    sda_d = 1'b0;
    #400;
    scl_d = 1'b0;
  endtask
  task automatic stop();
    #100;
    sda_d = 1'b0;
    hi();
    sda_d = 1'b1;
    #400;
  endtask
  task automatic xbyte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      #100;
      sda_d = b[i];
      hi();
      scl_d = 1'b0;
    end
    #100;
    sda_d = 1'b1;
    hi();
    ack = !o_sda;
    scl_d = 1'b0;
  endtask
endmodule
